// ---- common/las_pkg.sv ----
// shared constants, register map and types for the laser start-up sequencer
package las_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // register byte offsets
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_CFG = 8'h04;
   localparam logic [7:0] OFF_MODE = 8'h08;
   localparam logic [7:0] OFF_SETP = 8'h0C;
   localparam logic [7:0] OFF_WU_CUR = 8'h10;
   localparam logic [7:0] OFF_WU_TIME = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_ANA = 8'h1C;

   // command codes written to the command register
   localparam logic [2:0] CMD_ABORT = 3'h1;
   localparam logic [2:0] CMD_STOP = 3'h2;
   localparam logic [2:0] CMD_BEGIN = 3'h3;
   localparam logic [2:0] CMD_RELAUNCH = 3'h4;
   localparam logic [2:0] CMD_FAULT_CLR = 3'h5;

   // configuration bit positions and reset values
   localparam int CFG_AUTO_BIT = 0;
   localparam int CFG_REMOTE_BIT = 1;
   localparam logic [1:0] CFG_RESET = 2'h1;

   // status field positions
   localparam int ST_STATE_LSB = 0;
   localparam int ST_MODE_LSB = 4;
   localparam int ST_EMIT_BIT = 8;
   localparam int ST_THERMO_BIT = 9;
   localparam int ST_DRIVE_BIT = 10;
   localparam int ST_CLAMP_BIT = 11;

   // warm-up defaults: no warm-up
   localparam logic [15:0] WU_CUR_RESET = 16'h0000;
   localparam logic [15:0] WU_TIME_RESET = 16'h0000;

   // one second of pclk at 50 MHz
   localparam longint CLK_HZ = 50_000_000;
   localparam longint SECOND_S = 1;
   localparam int SEC_CYCLES = int'(CLK_HZ * SECOND_S);

   typedef enum logic [3:0] {
      LAS_STANDBY,
      LAS_WAIT_KEY,
      LAS_WAIT_REMOTE,
      LAS_WAIT_TEMP,
      LAS_WARMUP,
      LAS_ON,
      LAS_FAULT,
      LAS_ABORTED
   } las_state_e;

   typedef enum logic [1:0] {
      MODE_CONST_POWER,
      MODE_CONST_CURRENT,
      MODE_POWER_MOD,
      MODE_CURRENT_MOD
   } las_mode_e;

   localparam logic [1:0] MODE_RESET = 2'h0;

   // apb slave side group
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } las_apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [DATA_W-1:0] prdata;
   } las_apb_rsp_s;

   // drive outputs toward the diode and regulators
   typedef struct packed {
      logic emission_allowed;
      logic thermo_regulator_en;
      logic drive_en;
      logic [15:0] drive_current;
   } las_drive_s;

   // analog input selection
   typedef struct packed {
      logic impedance_high;
      logic range_5v;
   } las_ana_s;
endpackage : las_pkg

// ---- logic/las_sequencer.sv ----
// start-up and run-state sequencer for a laser module, apb register access
// What this block does
// RULE_01 - abort command or aborted start-up after a fault leads to Aborted
// RULE_02 - in Aborted emission is forbidden and thermo regulators are off
// RULE_03 - a fault enters Fault; Aborted follows only once it is cleared
// RULE_04 - Aborted is left only by restart command or power cycle
// RULE_05 - after power-up the first state is Standby
// RULE_06 - stop command returns to Standby
// RULE_07 - Standby holds emission off, enabled thermo regulators keep running
// RULE_08 - Standby resumes on begin or relaunch command or power cycle
// RULE_09 - key wait advances only on a key OFF to ON transition
// RULE_10 - with remote gating, wait for remote ON after the key turns ON
// RULE_11 - temperature wait ends when all regulators settle (at once without autostart), then warm-up
// RULE_12 - with autostart, no drive current before all setpoints reached
// RULE_13 - warm-up applies configured current for configured seconds, zero default
// RULE_14 - emission-on counts as ON and armed even with modulation low; here light_on drops in both modulation modes while modulation_in is low
// RULE_15 - exactly one run mode is active at any time
// RULE_16 - run mode resets to constant power
// RULE_17 - constant-power setpoints above nominal power are clamped
// RULE_18 - autostart enable resets to set
// RULE_19 - analog impedance and range apply in both modulation run modes
// RULE_20 - remote ON falling turns emission off and enters remote wait
// RULE_21 - after interlock opens, stay stopped until key toggle or power cycle
// RULE_22 - each state has a distinct code readable by the host
//
// Design decisions made here: the placing of the registers and the APB register port.
module las_sequencer #(
   parameter int N_THERMO = 2,
   parameter logic [15:0] NOMINAL_POWER = 16'h0190,
   parameter int SEC_COUNT = las_pkg::SEC_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire las_pkg::las_apb_req_s apb_req,
   output las_pkg::las_apb_rsp_s apb_rsp,
   input wire logic key_on,
   input wire logic remote_on,
   input wire logic interlock_closed,
   input wire logic fault_event,
   input wire logic [N_THERMO-1:0] thermo_settled,
   input wire logic modulation_in,
   output las_pkg::las_drive_s drive,
   output las_pkg::las_ana_s ana_sel,
   output logic [3:0] seq_state,
   output logic armed,
   output logic light_on
);
   import las_pkg::*;

   if (N_THERMO < 1 || SEC_COUNT < 1) begin : g_bad_param
      $error("las_sequencer: bad parameter");
   end

   las_state_e state;
   las_state_e next_state;
   las_mode_e mode;
   logic [1:0] cfg;
   logic [15:0] setpoint;
   logic [15:0] wu_cur;
   logic [15:0] wu_time;
   logic [1:0] ana;
   logic clamped;
   logic key_prev;
   logic remote_prev;
   logic fault_pend;
   logic [31:0] sec_cnt;
   logic [15:0] wu_secs;
   logic [DATA_W-1:0] rdata;

   logic wr_en;
   logic rd_en;
   logic cmd_wr;
   logic [2:0] cmd;
   logic key_rise;
   logic remote_fall;
   logic all_settled;
   logic wu_done;
   logic addr_ok;

   // single-cycle access phase: pready is always high
   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
   assign cmd_wr = wr_en & (apb_req.paddr == OFF_CMD);
   assign cmd = cmd_wr ? apb_req.pwdata[2:0] : 3'h0;
   assign key_rise = key_on & ~key_prev;
   assign remote_fall = ~remote_on & remote_prev;
   assign all_settled = &thermo_settled;
   assign wu_done = (wu_secs >= wu_time);

   always_comb begin
      case (apb_req.paddr)
         OFF_CMD, OFF_CFG, OFF_MODE, OFF_SETP,
         OFF_WU_CUR, OFF_WU_TIME, OFF_STATUS, OFF_ANA: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // a fault that arrives with the clear command stays pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_pend <= 1'b0;
      end else if (fault_event) begin
         fault_pend <= 1'b1;
      end else if (cmd == CMD_FAULT_CLR) begin
         fault_pend <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_prev <= 1'b1;
         remote_prev <= 1'b0;
      end else begin
         key_prev <= key_on;
         remote_prev <= remote_on;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         LAS_STANDBY: begin
            if (cmd == CMD_BEGIN || cmd == CMD_RELAUNCH) begin // see RULE_08
               next_state = LAS_WAIT_KEY;
            end
         end
         LAS_WAIT_KEY: begin
            if (key_rise && interlock_closed) begin // see RULE_09
               next_state = cfg[CFG_REMOTE_BIT] ? LAS_WAIT_REMOTE
                                                : LAS_WAIT_TEMP; // see RULE_10
            end
         end
         LAS_WAIT_REMOTE: begin
            if (remote_on) begin // see RULE_10
               next_state = LAS_WAIT_TEMP;
            end
         end
         LAS_WAIT_TEMP: begin
            // without autostart the temperature wait is bypassed
            if (all_settled || !cfg[CFG_AUTO_BIT]) begin // see RULE_11
               next_state = LAS_WARMUP;
            end
         end
         LAS_WARMUP: begin
            if (wu_done) begin // see RULE_13
               next_state = LAS_ON;
            end
         end
         LAS_ON: next_state = LAS_ON;
         LAS_FAULT: begin
            if (!fault_event &&
                (!fault_pend || cmd == CMD_FAULT_CLR)) begin // see RULE_03
               next_state = LAS_ABORTED;
            end
         end
         LAS_ABORTED: begin
            if (cmd == CMD_RELAUNCH) begin // see RULE_04
               next_state = LAS_STANDBY;
            end
         end
         default: next_state = LAS_STANDBY;
      endcase
      // common exits, faults first
      if (state != LAS_FAULT && state != LAS_ABORTED) begin
         if (fault_pend || fault_event) begin
            next_state = LAS_FAULT; // see RULE_03
         end else if (cmd == CMD_ABORT) begin
            next_state = LAS_ABORTED; // see RULE_01
         end else if (cmd == CMD_STOP) begin
            next_state = LAS_STANDBY; // see RULE_06
         end else if (!interlock_closed && state != LAS_STANDBY) begin
            // an opened loop forces a fresh key toggle
            next_state = LAS_WAIT_KEY; // see RULE_21
         end else if (cfg[CFG_REMOTE_BIT] && remote_fall &&
                      (state == LAS_WAIT_TEMP || state == LAS_WARMUP ||
                       state == LAS_ON)) begin
            next_state = LAS_WAIT_REMOTE; // see RULE_20
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= LAS_STANDBY; // see RULE_05
      end else begin
         state <= next_state;
      end
   end

   // warm-up seconds timer, restarted on every entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_cnt <= 32'h00000000;
         wu_secs <= 16'h0000;
      end else if (state != LAS_WARMUP) begin
         sec_cnt <= 32'h00000000;
         wu_secs <= 16'h0000;
      end else if (sec_cnt == 32'(SEC_COUNT - 1)) begin
         sec_cnt <= 32'h00000000;
         wu_secs <= wu_secs + 16'h0001; // see RULE_13
      end else begin
         sec_cnt <= sec_cnt + 32'h00000001;
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= CFG_RESET; // see RULE_18
         mode <= las_mode_e'(MODE_RESET); // see RULE_16
         setpoint <= 16'h0000;
         clamped <= 1'b0;
         wu_cur <= WU_CUR_RESET; // see RULE_13
         wu_time <= WU_TIME_RESET;
         ana <= 2'h0;
      end else if (wr_en) begin
         case (apb_req.paddr)
            OFF_CFG: cfg <= apb_req.pwdata[1:0];
            // a single enum field, so only one mode can ever be held
            OFF_MODE: mode <= las_mode_e'(apb_req.pwdata[1:0]); // see RULE_15
            OFF_SETP: begin
               if (apb_req.pwdata[15:0] > NOMINAL_POWER) begin
                  setpoint <= NOMINAL_POWER; // see RULE_17
                  clamped <= 1'b1;
               end else begin
                  setpoint <= apb_req.pwdata[15:0];
                  clamped <= 1'b0;
               end
            end
            OFF_WU_CUR: wu_cur <= apb_req.pwdata[15:0];
            OFF_WU_TIME: wu_time <= apb_req.pwdata[15:0];
            OFF_ANA: ana <= apb_req.pwdata[1:0];
            default: cfg <= cfg;
         endcase
      end
   end

   // drive outputs from flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive <= '0;
         armed <= 1'b0;
         light_on <= 1'b0;
      end else begin
         // regulators run everywhere except Aborted and Fault
         drive.thermo_regulator_en <= (state != LAS_ABORTED) &&
                                      (state != LAS_FAULT); // see RULE_02
         drive.emission_allowed <= (state == LAS_ON); // see RULE_07
         // no current before warm-up, which follows settled temperatures when autostart is set
         drive.drive_en <= (state == LAS_ON) ||
                           (state == LAS_WARMUP &&
                            wu_cur != 16'h0000); // see RULE_12
         drive.drive_current <= (state == LAS_WARMUP) ? wu_cur :
                                (state == LAS_ON) ? setpoint : 16'h0000;
         armed <= (state == LAS_ON); // see RULE_14
         light_on <= (state == LAS_ON) &&
                     ((mode == MODE_CONST_POWER) ||
                      (mode == MODE_CONST_CURRENT) || modulation_in);
      end
   end

   // analog selection applies only in the two modulation modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ana_sel <= '0;
      end else if (mode == MODE_POWER_MOD || mode == MODE_CURRENT_MOD) begin
         ana_sel <= ana; // see RULE_19
      end else begin
         ana_sel <= '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_state <= LAS_STANDBY;
      end else begin
         seq_state <= next_state; // see RULE_22
      end
   end

   // read data registered during setup, valid in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= 32'h00000000;
      end else if (apb_req.psel && !apb_req.penable) begin
         case (apb_req.paddr)
            OFF_CFG: rdata <= {30'h0, cfg};
            OFF_MODE: rdata <= {30'h0, mode};
            OFF_SETP: rdata <= {16'h0, setpoint};
            OFF_WU_CUR: rdata <= {16'h0, wu_cur};
            OFF_WU_TIME: rdata <= {16'h0, wu_time};
            OFF_ANA: rdata <= {30'h0, ana};
            OFF_STATUS: begin
               rdata <= {20'h0, clamped, drive.drive_en,
                         drive.thermo_regulator_en,
                         drive.emission_allowed,
                         2'h0, mode, state}; // see RULE_22
            end
            default: rdata <= 32'h00000000;
         endcase
      end
   end

   assign apb_rsp = '{pready: 1'b1,
                      pslverr: apb_req.psel & apb_req.penable & ~addr_ok,
                      prdata: rdata};
endmodule // las_sequencer

// ---- tb/las_operator.sv ----
// operator side model: key switch, remote input, regulator flags
module las_operator #(
   parameter int N = 2
) (
   input wire logic pclk,
   output logic key_on,
   output logic remote_on,
   output logic [N-1:0] thermo_settled
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      key_on = 1'b1;
      remote_on = 1'b0;
      thermo_settled = '0;
   end
   // key sits ON at power-up, so a start always needs off then on
   task automatic turn_key();
      @(posedge pclk) key_on <= 1'b0;
      repeat (3) @(posedge pclk);
      key_on <= 1'b1;
   endtask
   // regulators settle one at a time, gap cycles apart
   task automatic settle(input logic v, input int gap);
      for (int i = 0; i < N; i++) begin
         repeat (gap) @(posedge pclk);
         thermo_settled[i] <= v;
      end
   endtask
   task automatic set_remote(input logic v);
      @(posedge pclk) remote_on <= v;
   endtask
endmodule // las_operator

// ---- tb/las_sequencer_properties.sv ----
// port checker for the laser start-up sequencer
module las_seq_checker #(
   parameter int N_THERMO = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire las_pkg::las_apb_req_s apb_req,
   input wire las_pkg::las_apb_rsp_s apb_rsp,
   input wire logic key_on,
   input wire logic remote_on,
   input wire logic interlock_closed,
   input wire logic fault_event,
   input wire logic [N_THERMO-1:0] thermo_settled,
   input wire logic modulation_in,
   input wire las_pkg::las_drive_s drive,
   input wire las_pkg::las_ana_s ana_sel,
   input wire logic [3:0] seq_state,
   input wire logic armed,
   input wire logic light_on
);
   import las_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [2:0] code;
   // zero unless a command write completes this cycle
   assign code = (apb_req.psel & apb_req.penable & apb_req.pwrite
      & apb_req.paddr == OFF_CMD) ? apb_req.pwdata[2:0] : 3'h0;
   sequence s_next(logic [3:0] s);
      ##1 seq_state == s;
   endsequence
   property p_abort_safe;
      seq_state == 4'h7 && $past(seq_state) == 4'h7
         |-> !drive.emission_allowed && !drive.thermo_regulator_en;
   endproperty
   a_abort_safe: assert property (p_abort_safe) else $error("aborted");
   property p_standby_dark;
      seq_state == 4'h0 && $past(seq_state) == 4'h0
         |-> !drive.emission_allowed;
   endproperty
   a_standby_dark: assert property (p_standby_dark) else $error("standby");
   property p_fault_in;
      fault_event && seq_state != 4'h7 |-> s_next(4'h6);
   endproperty
   a_fault_in: assert property (p_fault_in) else $error("fault entry");
   property p_fault_hold;
      seq_state == 4'h6 && code != CMD_FAULT_CLR |-> s_next(4'h6);
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault left");
   property p_abort_hold;
      seq_state == 4'h7 && code != CMD_RELAUNCH && !fault_event
         |-> s_next(4'h7);
   endproperty
   a_abort_hold: assert property (p_abort_hold) else $error("abort left");
   property p_abort_cmd;
      code == CMD_ABORT && !fault_event && seq_state != 4'h6
         |-> s_next(4'h7);
   endproperty
   a_abort_cmd: assert property (p_abort_cmd) else $error("abort cmd");
   property p_key_hold;
      seq_state == 4'h1 && !(key_on && !$past(key_on)) && code == 3'h0
         && !fault_event |-> s_next(4'h1);
   endproperty
   a_key_hold: assert property (p_key_hold) else $error("key wait");
   property p_temp_hold;
      seq_state == 4'h3 && !(&thermo_settled) && code == 3'h0
         && !fault_event && interlock_closed && remote_on |-> s_next(4'h3);
   endproperty
   a_temp_hold: assert property (p_temp_hold) else $error("temp wait");
   property p_drive_gate;
      drive.drive_en |-> seq_state inside {4'h4, 4'h5}
         || $past(seq_state) inside {4'h4, 4'h5};
   endproperty
   a_drive_gate: assert property (p_drive_gate) else $error("early drive");
endmodule // las_seq_checker

bind las_sequencer las_seq_checker #(.N_THERMO(N_THERMO)) las_seq_checker_inst (
   .pclk, .presetn, .apb_req, .apb_rsp, .key_on, .remote_on,
   .interlock_closed, .fault_event, .thermo_settled, .modulation_in,
   .drive, .ana_sel, .seq_state, .armed, .light_on);

// ---- tb/las_sequencer_tb.sv ----
// self-checking testbench for the laser start-up sequencer
module las_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import las_pkg::*;
   logic pclk, presetn, interlock_closed, fault_event, modulation_in;
   logic key_on, remote_on, armed, light_on, err;
   logic [1:0] thermo_settled;
   logic [3:0] seq_state;
   logic [31:0] rd;
   las_apb_req_s apb_req;
   las_apb_rsp_s apb_rsp;
   las_drive_s drive;
   las_ana_s ana_sel;
   int n_mismatch = 0, comparisons = 0, cycles = 0;
   las_sequencer #(.SEC_COUNT(10)) las_sequencer_inst (.pclk, .presetn,
      .apb_req, .apb_rsp, .key_on, .remote_on, .interlock_closed,
      .fault_event, .thermo_settled, .modulation_in, .drive, .ana_sel,
      .seq_state, .armed, .light_on);
   las_operator #(.N(2)) las_operator_inst (.pclk, .key_on, .remote_on,
      .thermo_settled);
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
   task automatic ws(input logic [3:0] s);
      for (int n = 0; n < 60 && seq_state !== s; n++) @(negedge pclk);
      chk(seq_state, s);
   endtask
   task automatic stay(input logic [3:0] s, input int n);
      repeat (n) @(negedge pclk);
      chk(seq_state, s);
   endtask
   task automatic t_reset();
      apb(0, OFF_STATUS, 0);
      chk(rd, 32'h0000_0200);
      apb(0, OFF_CFG, 0);
      chk(rd, 32'h1);
      apb(0, OFF_MODE, 0);
      chk(rd, 32'h0);
      apb(0, OFF_WU_TIME, 0);
      chk(rd, 32'h0);
      apb(0, 8'h40, 0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
   endtask
   task automatic t_start();
      apb(1, OFF_CFG, 32'h3);
      apb(1, OFF_WU_CUR, 32'h55);
      apb(1, OFF_WU_TIME, 32'h1);
      apb(1, OFF_CMD, CMD_BEGIN);
      ws(LAS_WAIT_KEY);
      stay(LAS_WAIT_KEY, 8);
      las_operator_inst.turn_key();
      ws(LAS_WAIT_REMOTE);
      stay(LAS_WAIT_REMOTE, 5);
      las_operator_inst.set_remote(1'b1);
      ws(LAS_WAIT_TEMP);
      las_operator_inst.settle(1'b1, 6);
      @(negedge pclk);
      chk(drive.drive_en, 0);
      ws(LAS_WARMUP);
      @(negedge pclk);
      chk(drive.drive_current, 32'h55);
      ws(LAS_ON);
      @(negedge pclk);
      chk(armed, 1);
      chk(light_on, 1);
   endtask
   task automatic t_remote();
      las_operator_inst.set_remote(1'b0);
      ws(LAS_WAIT_REMOTE);
      @(negedge pclk);
      chk(drive.emission_allowed, 0);
      las_operator_inst.set_remote(1'b1);
      ws(LAS_ON);
      @(posedge pclk) interlock_closed <= 1'b0;
      ws(LAS_WAIT_KEY);
      @(posedge pclk) interlock_closed <= 1'b1;
      stay(LAS_WAIT_KEY, 6);
      las_operator_inst.turn_key();
      ws(LAS_ON);
   endtask
   task automatic t_abort();
      apb(1, OFF_CMD, CMD_STOP);
      ws(LAS_STANDBY);
      @(negedge pclk);
      chk(drive.emission_allowed, 0);
      chk(drive.thermo_regulator_en, 1);
      apb(1, OFF_CMD, CMD_BEGIN);
      ws(LAS_WAIT_KEY);
      apb(1, OFF_CMD, CMD_ABORT);
      ws(LAS_ABORTED);
      @(negedge pclk);
      chk({drive.emission_allowed, drive.thermo_regulator_en}, 0);
      apb(1, OFF_CMD, CMD_BEGIN);
      stay(LAS_ABORTED, 10);
      apb(1, OFF_CMD, CMD_RELAUNCH);
      ws(LAS_STANDBY);
      @(posedge pclk) fault_event <= 1'b1;
      @(posedge pclk) fault_event <= 1'b0;
      ws(LAS_FAULT);
      stay(LAS_FAULT, 10);
      apb(1, OFF_CMD, CMD_FAULT_CLR);
      ws(LAS_ABORTED);
      apb(1, OFF_CMD, CMD_RELAUNCH);
      ws(LAS_STANDBY);
   endtask
   task automatic t_mode();
      apb(1, OFF_SETP, 32'h1FF);
      apb(0, OFF_SETP, 0);
      chk(rd, 32'h190);
      apb(1, OFF_ANA, 32'h3);
      for (int m = 0; m < 4; m++) begin
         apb(1, OFF_MODE, m);
         apb(0, OFF_STATUS, 0);
         chk(rd & 32'h30, m << 4);
         chk(ana_sel, m >= 2 ? 3 : 0);
      end
   endtask
   initial begin
      presetn = 1'b0;
      apb_req = '0;
      interlock_closed = 1'b1;
      fault_event = 1'b0;
      modulation_in = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_start();
      t_remote();
      t_abort();
      t_mode();
      close_out();
   end
endmodule // las_sequencer_tb
